/* File: logic/watchdog_and_reset_status.sv */
// Watchdog timer with reset-cause register and bus-acknowledge recovery.
`timescale 1ns/1ps

module watchdog_and_reset_status #(
  parameter int PRESCALE_DIV     = watchdog_pkg::PRESCALE_DIV_DEFAULT,
  parameter int PERIOD_LOG2_BASE = watchdog_pkg::PERIOD_LOG2_BASE_DEFAULT
) (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic       clkEn,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output logic      [7:0] regRdData,
  input  wire logic       externalResetInputN,
  input  wire logic [2:0] irqLevelField,
  input  wire logic       iackStrobe,
  output logic            irqReq,
  output logic      [2:0] irqLevel,
  output logic      [7:0] vectorOut,
  output logic            vectorValid,
  output logic            busAck,
  output logic            internalReset,
  output logic            cpuResetReq
);

  // Last tick of a period: 2^(base + 2*code) ticks, counted from zero.
  function automatic logic [15:0] periodLast(input logic [1:0] code);
    int sh;
    sh = PERIOD_LOG2_BASE + watchdog_pkg::PERIOD_LOG2_STEP * int'(code);
    periodLast = 16'((32'd1 << sh) - 32'd1);
  endfunction

  // Address match for a register access.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] offset);
    hit = (a == offset);
  endfunction

  localparam logic [13:0] PRESCALE_LAST = 14'(PRESCALE_DIV - 1);

  // Pin synchroniser; the first stage feeds only the second.
  logic extRstMeta;
  logic extRstSync;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      extRstMeta <= 1'b0;
      extRstSync <= 1'b0;
    end else if (clkEn) begin
      extRstMeta <= ~externalResetInputN;
      extRstSync <= extRstMeta;
    end
  end

  // Register state.
  logic [7:0]  resetCause;
  logic [7:0]  control;
  logic [7:0]  vectorReg;
  logic        activePrescale;
  logic [1:0]  activePeriod;
  logic        serviceArmed;
  logic [13:0] prescaleCount;
  logic [15:0] tickCount;
  logic        irqPending;
  watchdog_pkg::reset_seq_e seqState;
  logic [4:0]  seqCount;

  logic [7:0]  next_resetCause;
  logic [7:0]  next_control;
  logic [7:0]  next_vectorReg;
  logic        next_activePrescale;
  logic [1:0]  next_activePeriod;
  logic        next_serviceArmed;
  logic [13:0] next_prescaleCount;
  logic [15:0] next_tickCount;
  logic        next_irqPending;
  watchdog_pkg::reset_seq_e next_seqState;
  logic [4:0]  next_seqCount;

  // Decoded accesses and events shared by the groups below.
  logic wrCause;
  logic wrControl;
  logic wrVector;
  logic wrService;
  logic serviceDone;
  logic tick;
  logic timeout;
  logic inReset;
  logic wdogResetStart;
  logic ackStart;

  always_comb begin
    wrCause   = regWrite && hit(regAddr, watchdog_pkg::RESET_CAUSE_OFFSET);
    wrControl = regWrite && hit(regAddr, watchdog_pkg::PROTECTION_CONTROL_OFFSET);
    wrVector  = regWrite && hit(regAddr, watchdog_pkg::WATCHDOG_VECTOR_OFFSET);
    wrService = regWrite && hit(regAddr, watchdog_pkg::WATCHDOG_SERVICE_OFFSET);
    serviceDone = wrService && serviceArmed &&
                  (regWrData == watchdog_pkg::SERVICE_RESTART_KEY);
    inReset = (seqState != watchdog_pkg::SEQ_RUN);
    // The prescaler only matters when selected; otherwise every enabled cycle outside reset is a tick.
    tick = control[watchdog_pkg::WATCHDOG_ENABLE_BIT] && !inReset &&
           (!activePrescale || (prescaleCount == PRESCALE_LAST));
    timeout = tick && (tickCount == periodLast(activePeriod));
    wdogResetStart = timeout && control[watchdog_pkg::TIMEOUT_ACTION_SELECT_BIT];
    ackStart = timeout && irqPending &&
               control[watchdog_pkg::BUS_ACK_ENABLE_BIT];
  end

  // Reset sequencer: external reset holds while the pin is low, watchdog reset is a pulse.
  always_comb begin
    next_seqState = seqState;
    next_seqCount = seqCount;
    unique case (seqState)
      watchdog_pkg::SEQ_RUN: begin
        if (extRstSync) begin
          next_seqState = watchdog_pkg::SEQ_EXT_RESET;
        end else if (wdogResetStart) begin
          next_seqState = watchdog_pkg::SEQ_WDOG_RESET;
          next_seqCount = '0;
        end
      end
      watchdog_pkg::SEQ_EXT_RESET: begin
        if (!extRstSync) begin
          next_seqState = watchdog_pkg::SEQ_RUN;
        end
      end
      watchdog_pkg::SEQ_WDOG_RESET: begin
        // The pin outranks a running watchdog reset.
        if (extRstSync) begin
          next_seqState = watchdog_pkg::SEQ_EXT_RESET;
        end else if (seqCount == watchdog_pkg::RESET_PULSE_CYCLES - 5'h01) begin
          next_seqState = watchdog_pkg::SEQ_RUN;
        end else begin
          next_seqCount = seqCount + 5'h01;
        end
      end
      default: begin
        next_seqState = watchdog_pkg::SEQ_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      seqState <= watchdog_pkg::SEQ_RUN;
      seqCount <= '0;
    end else if (clkEn) begin
      seqState <= next_seqState;
      seqCount <= next_seqCount;
    end
  end

  // Reset cause: rewritten whole when a reset completes, so stale flags never linger.
  always_comb begin
    next_resetCause = resetCause;
    if (wrCause) begin
      next_resetCause = resetCause & ~regWrData;
    end
    if (seqState == watchdog_pkg::SEQ_EXT_RESET && !extRstSync) begin
      next_resetCause = '0;
      next_resetCause[watchdog_pkg::EXTERNAL_RESET_FLAG_BIT] = 1'b1;
    end else if (seqState == watchdog_pkg::SEQ_WDOG_RESET && next_seqState ==
                 watchdog_pkg::SEQ_RUN) begin
      next_resetCause = '0;
      next_resetCause[watchdog_pkg::WATCHDOG_RESET_FLAG_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      resetCause <= watchdog_pkg::RESET_CAUSE_RESET;
    end else if (clkEn) begin
      resetCause <= next_resetCause;
    end
  end

  // Control, vector and service state; any reset operation returns them to defaults.
  always_comb begin
    next_control        = control;
    next_vectorReg      = vectorReg;
    next_activePrescale = activePrescale;
    next_activePeriod   = activePeriod;
    next_serviceArmed   = serviceArmed;
    if (inReset) begin
      next_control        = watchdog_pkg::PROTECTION_CONTROL_RESET;
      next_vectorReg      = watchdog_pkg::WATCHDOG_VECTOR_RESET;
      next_activePrescale = 1'b0;
      next_activePeriod   = 2'b00;
      next_serviceArmed   = 1'b0;
    end else begin
      if (wrControl && !irqPending) begin
        next_control[7:2] = regWrData[7:2];
        if (regWrData[watchdog_pkg::BUS_ACK_OCCURRED_BIT]) begin
          next_control[watchdog_pkg::BUS_ACK_OCCURRED_BIT] = 1'b0;
        end
      end
      // Setting the flag wins over a clear in the same cycle.
      if (ackStart) begin
        next_control[watchdog_pkg::BUS_ACK_OCCURRED_BIT] = 1'b1;
      end
      next_control[0] = 1'b0;
      if (wrVector) begin
        next_vectorReg = regWrData;
      end
      if (wrService) begin
        if (regWrData == watchdog_pkg::SERVICE_ARM_KEY) begin
          next_serviceArmed = 1'b1;
        end else if (serviceDone) begin
          next_serviceArmed   = 1'b0;
          // The selection written earlier becomes live only here.
          next_activePrescale = control[watchdog_pkg::TIMEOUT_PRESCALE_BIT];
          next_activePeriod   = control[watchdog_pkg::PERIOD_SELECT_HI:
                                        watchdog_pkg::PERIOD_SELECT_LO];
        end
        // Any other value leaves the armed state as it is.
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      control        <= watchdog_pkg::PROTECTION_CONTROL_RESET;
      vectorReg      <= watchdog_pkg::WATCHDOG_VECTOR_RESET;
      activePrescale <= 1'b0;
      activePeriod   <= 2'b00;
      serviceArmed   <= 1'b0;
    end else if (clkEn) begin
      control        <= next_control;
      vectorReg      <= next_vectorReg;
      activePrescale <= next_activePrescale;
      activePeriod   <= next_activePeriod;
      serviceArmed   <= next_serviceArmed;
    end
  end

  // Counter: it wraps at each timeout so a second period can be measured for the ack.
  always_comb begin
    next_prescaleCount = prescaleCount;
    next_tickCount     = tickCount;
    if (inReset || serviceDone) begin
      next_prescaleCount = '0;
      next_tickCount     = '0;
    end else if (control[watchdog_pkg::WATCHDOG_ENABLE_BIT]) begin
      if (activePrescale) begin
        next_prescaleCount = (prescaleCount == PRESCALE_LAST) ? 14'h0000 :
                             prescaleCount + 14'h0001;
      end
      if (timeout) begin
        next_tickCount = '0;
      end else if (tick) begin
        next_tickCount = tickCount + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      prescaleCount <= '0;
      tickCount     <= '0;
    end else if (clkEn) begin
      prescaleCount <= next_prescaleCount;
      tickCount     <= next_tickCount;
    end
  end

  // Interrupt pending: raised by a timeout in interrupt mode, dropped by acknowledge or by any reset operation.
  always_comb begin
    next_irqPending = irqPending;
    if (inReset) begin
      next_irqPending = 1'b0;
    end else if (timeout && !control[watchdog_pkg::TIMEOUT_ACTION_SELECT_BIT]) begin
      next_irqPending = 1'b1;
    end else if (iackStrobe && irqPending) begin
      next_irqPending = 1'b0;
    end
    // Service writes have no path to this flag.
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      irqPending <= 1'b0;
    end else if (clkEn) begin
      irqPending <= next_irqPending;
    end
  end

  // Output registers.
  logic [7:0] next_regRdData;
  logic       next_irqReq;
  logic [2:0] next_irqLevel;
  logic [7:0] next_vectorOut;
  logic       next_vectorValid;
  logic       next_busAck;
  logic       next_internalReset;
  logic       next_cpuResetReq;

  always_comb begin
    next_regRdData = 8'h00;
    if (regRead) begin
      if (hit(regAddr, watchdog_pkg::RESET_CAUSE_OFFSET)) begin
        next_regRdData = resetCause;
      end else if (hit(regAddr, watchdog_pkg::PROTECTION_CONTROL_OFFSET)) begin
        next_regRdData = control;
      end
      // Vector and service are write-only and read as zero, as do unmapped offsets.
    end
    next_irqReq   = next_irqPending;
    next_irqLevel = next_irqPending ? irqLevelField : 3'h0;
    next_vectorValid = iackStrobe && irqPending && !inReset;
    next_vectorOut   = next_vectorValid ? vectorReg : 8'h00;
    next_busAck      = ackStart && !inReset;
    next_internalReset = (next_seqState != watchdog_pkg::SEQ_RUN);
    next_cpuResetReq   = (next_seqState == watchdog_pkg::SEQ_EXT_RESET);
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      regRdData     <= 8'h00;
      irqReq        <= 1'b0;
      irqLevel      <= 3'h0;
      vectorOut     <= 8'h00;
      vectorValid   <= 1'b0;
      busAck        <= 1'b0;
      internalReset <= 1'b0;
      cpuResetReq   <= 1'b0;
    end else if (clkEn) begin
      regRdData     <= next_regRdData;
      irqReq        <= next_irqReq;
      irqLevel      <= next_irqLevel;
      vectorOut     <= next_vectorOut;
      vectorValid   <= next_vectorValid;
      busAck        <= next_busAck;
      internalReset <= next_internalReset;
      cpuResetReq   <= next_cpuResetReq;
    end
  end

endmodule

/* File: logic/watchdog_pkg.sv */
// Constants for the watchdog and reset-cause block.
package watchdog_pkg;

  // Register offsets on the byte-wide register port.
  localparam logic [7:0] RESET_CAUSE_OFFSET        = 8'h00;
  localparam logic [7:0] PROTECTION_CONTROL_OFFSET = 8'h01;
  localparam logic [7:0] WATCHDOG_VECTOR_OFFSET    = 8'h02;
  localparam logic [7:0] WATCHDOG_SERVICE_OFFSET   = 8'h03;

  // Reset-cause field positions.
  localparam int EXTERNAL_RESET_FLAG_BIT = 7;
  localparam int WATCHDOG_RESET_FLAG_BIT = 6;

  // Protection control field positions.
  localparam int WATCHDOG_ENABLE_BIT       = 7;
  localparam int TIMEOUT_ACTION_SELECT_BIT = 6;
  localparam int TIMEOUT_PRESCALE_BIT      = 5;
  localparam int PERIOD_SELECT_HI          = 4;
  localparam int PERIOD_SELECT_LO          = 3;
  localparam int BUS_ACK_ENABLE_BIT        = 2;
  localparam int BUS_ACK_OCCURRED_BIT      = 1;

  // Values after reset.
  localparam logic [7:0] RESET_CAUSE_RESET        = 8'h80;
  localparam logic [7:0] PROTECTION_CONTROL_RESET = 8'h00;
  localparam logic [7:0] WATCHDOG_VECTOR_RESET    = 8'h0f;

  // Service sequence keys.
  localparam logic [7:0] SERVICE_ARM_KEY     = 8'h55;
  localparam logic [7:0] SERVICE_RESTART_KEY = 8'haa;

  // Cycle counts and log2 exponents of periods.
  localparam int          PRESCALE_DIV_DEFAULT     = 8192;
  localparam int          PERIOD_LOG2_BASE_DEFAULT = 9;
  localparam int          PERIOD_LOG2_STEP         = 2;
  localparam logic [4:0]  RESET_PULSE_CYCLES       = 5'h10;

  // Reset sequencer states.
  typedef enum logic [1:0] {
    SEQ_RUN        = 2'b00,
    SEQ_EXT_RESET  = 2'b01,
    SEQ_WDOG_RESET = 2'b10
  } reset_seq_e;

endpackage

/* File: verification/irq_host_model.sv */
// Processor-side model that answers the watchdog interrupt with acknowledge cycles.
`timescale 1ns/1ps
module irq_host_model (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic       respond,
  input  wire logic [3:0] ackDelay,
  input  wire logic       irqReq,
  input  wire logic [7:0] vectorOut,
  input  wire logic       vectorValid,
  output logic            iackStrobe,
  output logic      [7:0] lastVector
);
  logic [3:0] waitCnt;
  logic       busy;

  // Busy blocks a second acknowledge until the vector arrives, as a real core would.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      waitCnt <= 4'h0;
      busy <= 1'b0;
      iackStrobe <= 1'b0;
      lastVector <= 8'h00;
    end else begin
      iackStrobe <= 1'b0;
      if (vectorValid) begin
        lastVector <= vectorOut;
        busy <= 1'b0;
      end
      if (irqReq && respond && !busy) begin
        if (waitCnt >= ackDelay) begin
          iackStrobe <= 1'b1;
          busy <= 1'b1;
          waitCnt <= 4'h0;
        end else begin
          waitCnt <= waitCnt + 4'h1;
        end
      end
    end
  end
endmodule

/* File: verification/tb_watchdog_and_reset_status.sv */
// Self-checking bench for the watchdog and reset-status block.
`timescale 1ns/1ps
module tb_watchdog_and_reset_status;
  localparam int DIV = 4;
  typedef struct { logic [7:0] ctrl; logic [7:0] vec; int per; } row_s;
  logic       clk_sys, sys_rst, clkEn, regWrite, regRead, externalResetInputN, iackStrobe;
  logic       irqReq, vectorValid, busAck, internalReset, cpuResetReq, respond;
  logic [7:0] regAddr, regWrData, regRdData, vectorOut, lastVector;
  logic [2:0] irqLevelField, irqLevel;
  logic [3:0] ackDelay;
  int         num_errors, n_checks, n;
  // Short periods: base 2 gives 4, 16, 64, 256 cycles, prescale multiplies by DIV.
  row_s rows [8] = '{'{8'h80, 8'h0f, 4}, '{8'h88, 8'h41, 16}, '{8'h90, 8'h42, 64},
    '{8'h98, 8'h43, 256}, '{8'ha0, 8'h44, 16}, '{8'ha8, 8'h45, 64},
    '{8'hb0, 8'h46, 256}, '{8'hb8, 8'h47, 1024}};

  watchdog_and_reset_status #(.PRESCALE_DIV(DIV), .PERIOD_LOG2_BASE(2)) watchdog_and_reset_status_i (
    .clk_sys, .sys_rst, .clkEn, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
    .externalResetInputN, .irqLevelField, .iackStrobe, .irqReq, .irqLevel, .vectorOut,
    .vectorValid, .busAck, .internalReset, .cpuResetReq);
  irq_host_model irq_host_model_i (.clk_sys, .sys_rst, .respond, .ackDelay, .irqReq,
    .vectorOut, .vectorValid, .iackStrobe, .lastVector);

  // Free-running bus clock.
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // Bus and compare helpers; drive right after an edge, sample 1 ns past it.
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chkCnt(input string nm, input int lo, input int hi, input int got);
    n_checks++;
    if (got < lo || got > hi) begin
      num_errors++;
      $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1;
    chk(nm, exp, regRdData);
  endtask
  task automatic serv();
    wr(8'h03, 8'h55);
    wr(8'h03, 8'haa);
  endtask
  task automatic rst();
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
  endtask
  task automatic waitIrq();
    n = 0;
    while (irqReq !== 1'b1 && n < 3000) begin
      tick(1);
      n++;
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Guard against a hang; the tests need well under this span.
  initial begin
    #(4 * 20000);
    num_errors++;
    summarize();
  end

  initial begin
    sys_rst = 1'b1;
    {clkEn, externalResetInputN} = 2'b11;
    {regWrite, regRead, respond} = 3'b000;
    {regAddr, regWrData, irqLevelField, ackDelay} = '0;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd("cause", 8'h00, 8'h80);
    rd("control", 8'h01, 8'h00);
    rd("vector", 8'h02, 8'h00);
    rd("service", 8'h03, 8'h00);
    rd("unmapped", 8'h10, 8'h00);
    tick(20);
    chk("idle irq", 8'h00, {7'h0, irqReq});
    // Every period and prescale choice, each with its own vector and level.
    foreach (rows[i]) begin
      rst();
      irqLevelField <= i[2:0];
      respond <= 1'b1;
      ackDelay <= 4'(i);
      if (rows[i].vec !== 8'h0f) wr(8'h02, rows[i].vec);
      // Load the selection while disabled, so the count starts at the enabling write.
      wr(8'h01, rows[i].ctrl & 8'h7f);
      serv();
      wr(8'h01, rows[i].ctrl);
      waitIrq();
      chkCnt("period", rows[i].per, rows[i].per + DIV + 2, n);
      chk("level", {5'h0, i[2:0]}, {5'h0, irqLevel});
      tick(22);
      chk("vec", rows[i].vec, lastVector);
    end
    // A new period waits for the service pair; the reset period still rules.
    rst();
    respond <= 1'b0;
    wr(8'h01, 8'h98);
    waitIrq();
    chkCnt("unloaded period", 3, 7, n);
    // A stray value between the keys neither clears nor disarms.
    rst();
    wr(8'h01, 8'h08);
    serv();
    wr(8'h01, 8'h88);
    wr(8'h03, 8'h55);
    tick(6);
    wr(8'h03, 8'h33);
    wr(8'h03, 8'haa);
    waitIrq();
    chkCnt("restart", 16, 18, n);
    // A low clock enable freezes the count; it resumes where it stopped.
    rst();
    wr(8'h01, 8'h80);
    @(posedge clk_sys);
    clkEn <= 1'b0;
    tick(20);
    chk("frozen irq", 8'h00, {7'h0, irqReq});
    @(posedge clk_sys);
    clkEn <= 1'b1;
    waitIrq();
    chkCnt("resumed period", 3, 3, n);
    // Pending interrupt locks control, survives service, then bus ack fires.
    rst();
    wr(8'h01, 8'h14);
    serv();
    wr(8'h01, 8'h94);
    waitIrq();
    wr(8'h01, 8'h00);
    rd("locked", 8'h01, 8'h94);
    serv();
    tick(1);
    chk("pending", 8'h01, {7'h0, irqReq});
    n = 0;
    while (busAck !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    chkCnt("ack wait", 60, 67, n);
    rd("ack flag", 8'h01, 8'h96);
    ackDelay <= 4'h1;
    respond <= 1'b1;
    tick(8);
    wr(8'h01, 8'h16);
    rd("ack clear", 8'h01, 8'h14);
    // Timeout in reset mode, then the external pin.
    rst();
    wr(8'h01, 8'h40);
    serv();
    wr(8'h01, 8'hc0);
    n = 0;
    while (internalReset !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    chkCnt("reset time", 3, 7, n);
    chk("no irq", 8'h00, {7'h0, irqReq});
    tick(20);
    rd("wdog cause", 8'h00, 8'h40);
    // Software clears the flag; the next reset must still set its own cause.
    wr(8'h00, 8'h40);
    rd("cause clear", 8'h00, 8'h00);
    @(posedge clk_sys);
    externalResetInputN <= 1'b0;
    tick(6);
    chk("cpu reset", 8'h01, {7'h0, cpuResetReq});
    @(posedge clk_sys);
    externalResetInputN <= 1'b1;
    tick(6);
    rd("ext cause", 8'h00, 8'h80);
    rd("ext control", 8'h01, 8'h00);
    summarize();
  end
endmodule

/* File: verification/watchdog_checker_assertions.sv */
// Port-level checker for the watchdog and reset-status block.
`timescale 1ns/1ps
module watchdog_checker (
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  input wire logic       regRead,
  input wire logic [7:0] regRdData,
  input wire logic       externalResetInputN,
  input wire logic [2:0] irqLevelField,
  input wire logic       iackStrobe,
  input wire logic       irqReq,
  input wire logic [2:0] irqLevel,
  input wire logic [7:0] vectorOut,
  input wire logic       vectorValid,
  input wire logic       busAck,
  input wire logic       internalReset,
  input wire logic       cpuResetReq
);
  // One clock domain, so clocking and reset are given once.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // Interrupt answer, vector and level.
  a_iack_answer: assert property (irqReq && iackStrobe |=> vectorValid && !irqReq)
    else $error("iack not answered");
  a_vector_idle: assert property (!vectorValid |-> vectorOut == 8'h00)
    else $error("vector outside answer");
  a_level_track: assert property (irqReq && $stable(irqLevelField) |-> irqLevel == irqLevelField)
    else $error("irq level wrong");
  a_pending_held: assert property (irqReq && !iackStrobe && externalResetInputN |=> irqReq)
    else $error("pending dropped");
  a_busack_cause: assert property (busAck |-> $past(irqReq))
    else $error("bus ack without pending");

  // Reset outputs and idle read data; the watchdog pulse lasts 16 cycles.
  a_wdog_pulse: assert property ($rose(internalReset) && !cpuResetReq |->
    internalReset [*8] ##1 internalReset [*8] ##1 !internalReset)
    else $error("watchdog reset length");
  a_cpu_reset: assert property (cpuResetReq |-> internalReset)
    else $error("cpu reset alone");
  a_ext_entry: assert property ($fell(externalResetInputN) |-> ##[1:6] cpuResetReq)
    else $error("external reset missed");
  a_read_idle: assert property (!$past(regRead) |-> regRdData == 8'h00)
    else $error("read data outside slot");
endmodule

bind watchdog_and_reset_status watchdog_checker watchdog_checker_i (.clk_sys, .sys_rst,
  .regRead, .regRdData, .externalResetInputN, .irqLevelField, .iackStrobe, .irqReq,
  .irqLevel, .vectorOut, .vectorValid, .busAck, .internalReset, .cpuResetReq);
